// ### pkg/adc_cfg_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Included by the package and by every design module
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH

`define NUM_CH          3
`define ADDR_W          8

`define OFS_CHAN_CFG    8'h00
`define OFS_GAIN        8'h04
`define OFS_CLOCK       8'h08
`define OFS_SUPPLY      8'h0c
`define OFS_STATUS      8'h10

`define SEL_W           2
`define GAIN_W          3
`define GAIN_STRIDE     4
`define DIV_POS         0
`define POWER_POS       2
`define BAND_W          4
`define ST_SETTLED_POS  0
`define ST_BAND_POS     1
`define ST_RATIO_POS    4
`define ST_HALF_POS     8

`define RST_CHAN_CFG    6'h00
`define RST_GAIN        9'h000
`define RST_DIV         2'h0
`define RST_POWER       2'h2
`define RST_BAND        4'h0

`define PRECHARGE_MIN   3'h3
`define FSR_UNITY_UV    21'h124f80
`define TEST_UNITY_UV   21'h027100
`define LEVEL_W         21

`define CLK_PERIOD_NS   4
`define REF_SETTLE_NS   2000
`define REF_SETTLE_CYC  ((`REF_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_W        10

`define HALF_DIV2       3'h1
`define HALF_DIV4       3'h2
`define HALF_DIV8       3'h4
`define HALF_DIV12      3'h6

`endif

// ### pkg/adc_cfg_pkg.sv
// Purpose: Shared types of the converter configuration block
// Assumes: Constants come from adc_cfg_defs.svh
// Notes:   Enumerations and per-channel vector types only, no numbers beyond their codes
`include "adc_cfg_defs.svh"

package adc_cfg_pkg;

  typedef enum logic [1:0] {
    SEL_ANALOG   = 2'h0,
    SEL_GROUND   = 2'h1,
    SEL_TEST_POS = 2'h2,
    SEL_TEST_NEG = 2'h3
  } input_select_type;

  typedef enum logic [1:0] {
    POWER_LOW     = 2'h0,
    POWER_LOW_ALT = 2'h1,
    POWER_HIGHRES = 2'h2,
    POWER_HI_ALT  = 2'h3
  } power_mode_type;

  typedef enum logic [1:0] {
    REF_WAIT  = 2'h1,
    REF_READY = 2'h2
  } ref_state_type;

  typedef logic [`NUM_CH-1:0][3:0]           route_vec_type;
  typedef logic [`NUM_CH-1:0][`LEVEL_W-1:0]  level_vec_type;
  typedef logic [`NUM_CH-1:0][`GAIN_W-1:0]   gain_vec_type;

endpackage

// ### core/mod_clock_divider.sv
// Purpose: Divides the main clock into a 50% duty modulator clock
// Assumes: Ratio code 0..3 selects 2, 4, 8 or 12
// Notes:   A new ratio is taken only at a falling edge of the modulator clock,
//          so no short pulse appears when software changes it
`include "adc_cfg_defs.svh"

module mod_clock_divider
  import adc_cfg_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [1:0] ratioSel,
  output logic            modClk_q,
  output logic            modTick_q,
  output logic [2:0]      half_q
);

  logic [2:0] cnt_q;
  logic [2:0] halfSel;
  logic       wrap;

  assign halfSel = (ratioSel == 2'h0) ? `HALF_DIV2 :
                   (ratioSel == 2'h1) ? `HALF_DIV4 :
                   (ratioSel == 2'h2) ? `HALF_DIV8 : `HALF_DIV12;
  assign wrap = (cnt_q == half_q - 3'h1);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q     <= 3'h0;
      half_q    <= `HALF_DIV2;
      modClk_q  <= 1'b0;
      modTick_q <= 1'b0;
    end else begin
      cnt_q     <= wrap ? 3'h0 : cnt_q + 3'h1;
      modClk_q  <= wrap ? ~modClk_q : modClk_q;
      modTick_q <= wrap & ~modClk_q;
      if (wrap & modClk_q) begin
        half_q <= halfSel;
      end
    end
  end

  // Level length counted from the clock output itself, not from the
  // divider counter, so a counter fault cannot hide from the check
  logic       lastClk_q;
  logic [2:0] runLen_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lastClk_q <= 1'b0;
      runLen_q  <= 3'h0;
    end else begin
      lastClk_q <= modClk_q;
      runLen_q  <= (modClk_q != lastClk_q) ? 3'h1 : runLen_q + 3'h1;
    end
  end

  a_half_length: assert property (@(posedge ref_clk) disable iff (!resetn)
    (modClk_q != lastClk_q) |-> runLen_q == $past(half_q))
    else $error("modulator level length differs from half period");

  a_ratio_code: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wrap && modClk_q && ratioSel == 2'h3) |=> half_q == 3'h6)
    else $error("ratio code 3 did not give twelve");

endmodule

// ### core/channel_path.sv
// Purpose: One channel's selector, gain, precharge and level scaling
// Assumes: Levels are in microvolts; gain is a power of two
// Notes:   Both levels shift by the same gain, so the test level
//          stays exactly two fifteenths of full scale
`include "adc_cfg_defs.svh"

module channel_path
  import adc_cfg_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  input_select_type            inSel,
  input  wire logic [`GAIN_W-1:0]     gainSel,
  output logic [3:0]                  route_q,
  output logic                        precharge_q,
  output logic [`LEVEL_W-1:0]         fullScale_q,
  output logic [`LEVEL_W-1:0]         testLevel_q
);

  logic [3:0] routeD;

  // Bit 0 analog pins, 1 isolated ground, 2 test +, 3 test -
  assign routeD = 4'h1 << inSel;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      route_q     <= 4'h1;
      precharge_q <= 1'b0;
      fullScale_q <= `FSR_UNITY_UV;
      testLevel_q <= `TEST_UNITY_UV;
    end else begin
      route_q     <= routeD;
      precharge_q <= (gainSel >= `PRECHARGE_MIN);
      fullScale_q <= `FSR_UNITY_UV >> gainSel;
      testLevel_q <= `TEST_UNITY_UV >> gainSel;
    end
  end

  a_route_onehot: assert property (@(posedge ref_clk) disable iff (!resetn)
    ##1 $onehot(route_q) && route_q == 4'h1 << $past(inSel))
    else $error("route does not follow selector");

  a_precharge_gain: assert property (@(posedge ref_clk) disable iff (!resetn)
    $stable(gainSel) |=> precharge_q == ($past(gainSel) > 3'h2))
    else $error("precharge buffer wrong for gain");

  a_test_ratio: assert property (@(posedge ref_clk) disable iff (!resetn)
    25'(testLevel_q) * 25'd15 == 25'(fullScale_q) * 25'd2)
    else $error("test level not two fifteenths of full scale");

endmodule

// ### core/adc_channel_clock_config.sv
// Purpose: Configuration of a three-channel isolated converter
// Assumes: ref_clk is the main clock input, 250 MHz
// Notes:   APB slave with one wait state; all outputs registered
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`include "adc_cfg_defs.svh"

module adc_channel_clock_config
  import adc_cfg_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic [`ADDR_W-1:0]  paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  output adc_cfg_pkg::route_vec_type routeSel,
  output adc_cfg_pkg::gain_vec_type  channelGainSel,
  output logic [`NUM_CH-1:0]       prechargeEnable,
  output adc_cfg_pkg::level_vec_type fullScaleUv,
  output adc_cfg_pkg::level_vec_type testLevelUv,
  output logic                     highResolutionMode,
  output logic                     lowPowerMode,
  output logic                     modulatorClock,
  output logic                     modulatorTick,
  output logic [`BAND_W-1:0]       supplyConverterBandCode,
  output logic                     conversionEnable
);

  import adc_cfg_pkg::*;

  // Register state
  logic [`NUM_CH*`SEL_W-1:0]       chanCfg_q;
  logic [`NUM_CH*`GAIN_STRIDE-1:0] gain_q;
  logic [1:0]                      divSel_q;
  power_mode_type                  powerSel_q;
  logic [`BAND_W-1:0]              band_q;
  logic                            bandWritten_q;
  logic                            ready_q;
  logic [31:0]                     rdata_q;
  logic                            slvErr_q;
  logic                            highRes_q;
  logic                            lowPow_q;
  logic [`BAND_W-1:0]              bandOut_q;
  ref_state_type                   refState_q;
  logic [`SETTLE_W-1:0]            settleCnt_q;
  logic                            convEn_q;

  // Bus decode
  logic        access;
  logic        firstAccess;
  logic        doWrite;
  logic        hitChan;
  logic        hitGain;
  logic        hitClock;
  logic        hitSupply;
  logic        hitStatus;
  logic        mapped;
  logic        roViolation;
  logic [15:0] laneMask;
  logic [31:0] readMux;
  logic [2:0]  halfNow;
  logic        modClkInt;
  logic        modTickInt;

  assign access      = psel & penable;
  assign firstAccess = access & ~ready_q;
  assign doWrite     = access & ready_q & pwrite & ~slvErr_q;
  assign hitChan     = (paddr == `OFS_CHAN_CFG);
  assign hitGain     = (paddr == `OFS_GAIN);
  assign hitClock    = (paddr == `OFS_CLOCK);
  assign hitSupply   = (paddr == `OFS_SUPPLY);
  assign hitStatus   = (paddr == `OFS_STATUS);
  assign mapped      = hitChan | hitGain | hitClock | hitSupply
                     | hitStatus;
  // Status is read-only; a write to it is refused like a hole
  assign roViolation = hitStatus & pwrite;
  assign laneMask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  assign readMux =
      hitChan   ? {26'h0, chanCfg_q} :
      hitGain   ? {20'h0, gain_q} :
      hitClock  ? {28'h0, powerSel_q, divSel_q} :
      hitSupply ? {28'h0, band_q} :
      hitStatus ? {20'h0, 1'b0, halfNow, 2'h0, divSel_q,
                   2'h0, bandWritten_q, convEn_q} :
      32'h0;

  // One wait state keeps prdata straight from a flop
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ready_q  <= 1'b0;
      rdata_q  <= 32'h0;
      slvErr_q <= 1'b0;
    end else begin
      ready_q  <= firstAccess;
      slvErr_q <= firstAccess & (~mapped | roViolation);
      if (firstAccess & ~pwrite) begin
        rdata_q <= readMux;
      end
    end
  end

  assign pready  = ready_q;
  assign prdata  = rdata_q;
  assign pslverr = slvErr_q;

  // Writes take effect at the edge that samples pready high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      chanCfg_q     <= `RST_CHAN_CFG;
      gain_q        <= {3'h0, `RST_GAIN};
      divSel_q      <= `RST_DIV;
      powerSel_q    <= POWER_HIGHRES;
      band_q        <= `RST_BAND;
      bandWritten_q <= 1'b0;
    end else if (doWrite) begin
      if (hitChan) begin
        chanCfg_q <= 6'(merge(16'(chanCfg_q), pwdata[15:0],
                              laneMask));
      end
      if (hitGain) begin
        gain_q <= 12'(merge(16'(gain_q), pwdata[15:0],
                            laneMask) & 16'h0777);
      end
      if (hitClock & pstrb[0]) begin
        divSel_q   <= pwdata[`DIV_POS +: 2];
        powerSel_q <= power_mode_type'(pwdata[`POWER_POS +: 2]);
      end
      if (hitSupply & pstrb[0]) begin
        band_q        <= pwdata[`BAND_W-1:0];
        bandWritten_q <= 1'b1;
      end
    end
  end

  // Power field: bit 1 set means high resolution bias
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      highRes_q <= 1'b1;
      lowPow_q  <= 1'b0;
      bandOut_q <= `RST_BAND;
    end else begin
      highRes_q <= powerSel_q[1];
      lowPow_q  <= ~powerSel_q[1];
      bandOut_q <= band_q;
    end
  end

  assign highResolutionMode      = highRes_q;
  assign lowPowerMode            = lowPow_q;
  assign supplyConverterBandCode = bandOut_q;

  // Reference settling: conversions are held off until it ends.
  // The count is conservative; a real part would watch a comparator.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      refState_q  <= REF_WAIT;
      settleCnt_q <= '0;
      convEn_q    <= 1'b0;
    end else begin
      case (refState_q)
        REF_WAIT: begin
          settleCnt_q <= settleCnt_q + 10'h1;
          if (settleCnt_q == 10'(`REF_SETTLE_CYC - 1)) begin
            refState_q <= REF_READY;
            convEn_q   <= 1'b1;
          end
        end
        REF_READY: begin
          convEn_q <= 1'b1;
        end
        default: begin
          refState_q <= REF_WAIT;
          convEn_q   <= 1'b0;
        end
      endcase
    end
  end

  assign conversionEnable = convEn_q;

  mod_clock_divider divider (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .ratioSel  (divSel_q),
    .modClk_q  (modClkInt),
    .modTick_q (modTickInt),
    .half_q    (halfNow)
  );

  assign modulatorClock = modClkInt;
  assign modulatorTick  = modTickInt;

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch = ch + 1) begin : g_ch
      logic [3:0] routeQ;
      logic       preQ;
      logic [`LEVEL_W-1:0] fsQ;
      logic [`LEVEL_W-1:0] tlQ;
      logic [`GAIN_W-1:0]  gainQ;

      assign gainQ = gain_q[ch*`GAIN_STRIDE +: `GAIN_W];

      channel_path path (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .inSel       (input_select_type'(
                        chanCfg_q[ch*`SEL_W +: `SEL_W])),
        .gainSel     (gainQ),
        .route_q     (routeQ),
        .precharge_q (preQ),
        .fullScale_q (fsQ),
        .testLevel_q (tlQ)
      );

      assign routeSel[ch]        = routeQ;
      assign prechargeEnable[ch] = preQ;
      assign fullScaleUv[ch]     = fsQ;
      assign testLevelUv[ch]     = tlQ;
    end
  endgenerate

  // Gain echoed from its register for the analog side
  assign channelGainSel = gain_vec_type'({gain_q[10:8], gain_q[6:4],
                                          gain_q[2:0]});

  sequence s_write_clock;
    psel && penable && pready && pwrite && !pslverr
      && paddr == `OFS_CLOCK && pstrb[0];
  endsequence

  sequence s_first_access;
    psel && penable && !pready;
  endsequence

  a_clock_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_write_clock |=> divSel_q == $past(pwdata[1:0])
                      && powerSel_q == $past(pwdata[3:2]))
    else $error("clock register write lost");

  a_power_outputs: assert property (@(posedge ref_clk) disable iff (!resetn)
    ##1 highResolutionMode == $past(powerSel_q[1])
        && lowPowerMode != highResolutionMode)
    else $error("power mode outputs wrong");

  a_ready_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_first_access |=> pready)
    else $error("slave did not answer after one wait");

  a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!resetn)
    pslverr |-> pready && !$past(mapped && !roViolation))
    else $error("error on a mapped register");

  a_ref_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    refState_q == REF_WAIT |-> !conversionEnable)
    else $error("conversion enabled before reference settled");

  a_settle_time: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(conversionEnable) |-> $past(settleCnt_q) == 10'd499)
    else $error("reference settle time wrong");

  a_band_output: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(band_q) |=> supplyConverterBandCode == $past(band_q))
    else $error("band code not passed to supply converter");

  a_default_ratio: assert property (@(posedge ref_clk) disable iff (!resetn)
    (divSel_q == 2'h0 && halfNow == 3'h1)
      |=> modulatorClock != $past(modulatorClock))
    else $error("default ratio is not two");

  sequence s_write_supply;
    psel && penable && pready && pwrite && !pslverr
      && paddr == `OFS_SUPPLY && pstrb[0];
  endsequence

  a_div_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (psel && penable && pready && pwrite && paddr == `OFS_CLOCK
      && !pstrb[0]) |=> $stable(divSel_q) && $stable(powerSel_q))
    else $error("clock field written without its byte strobe");

  a_band_set: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_write_supply |=> band_q == $past(pwdata[3:0]) && bandWritten_q)
    else $error("band code write not stored");

endmodule

// ### test/host_model.sv
// Purpose: Host side model: main clock source and APB master
// Assumes: The device answers each transfer within 16 cycles
// Notes:   Signals change only by NBA just after a rising edge
`include "adc_cfg_defs.svh"

module host_model
  import adc_cfg_pkg::*;
(
  output logic               ref_clk,
  input  wire logic          resetn,
  output logic [`ADDR_W-1:0] paddr,
  output logic               psel,
  output logic               penable,
  output logic               pwrite,
  output logic [31:0]        pwdata,
  output logic [3:0]         pstrb,
  input  wire logic          pready,
  input  wire logic [31:0]   prdata,
  input  wire logic          pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Free running: the device needs it for the whole run
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
  end

  task automatic xfer(input logic wr, input logic [`ADDR_W-1:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err,
                      output bit ok);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    ok = 1'b0;
    // Request held until pready is seen high at an edge
    for (k = 0; k < 16 && !ok; k++) begin
      @(posedge ref_clk);
      ok = (pready === 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### test/testbench.sv
// Purpose: Self-checking bench of the converter configuration block
// Assumes: Outputs follow a register write within three cycles
// Notes:   Expected values are derived from gain and ratio codes
`include "adc_cfg_defs.svh"

module testbench
  import adc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 ref_clk;
  logic                 resetn;
  logic [`ADDR_W-1:0]   paddr;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [31:0]          pwdata;
  logic [3:0]           pstrb;
  logic                 pready;
  logic [31:0]          prdata;
  logic                 pslverr;
  route_vec_type        routeSel;
  gain_vec_type         chGain;
  logic [`NUM_CH-1:0]   precharge;
  level_vec_type        fullScale;
  level_vec_type        testLevel;
  logic                 highRes;
  logic                 lowPower;
  logic                 modClk;
  logic                 modTick;
  logic [`BAND_W-1:0]   band;
  logic                 convEn;
  logic [31:0]          rd;
  logic                 err;
  int                   nErrors;
  int                   cmpCount;
  int                   sinceRel;

  adc_channel_clock_config adc_channel_clock_config_i (
    .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .routeSel(routeSel), .channelGainSel(chGain),
    .prechargeEnable(precharge), .fullScaleUv(fullScale),
    .testLevelUv(testLevel), .highResolutionMode(highRes),
    .lowPowerMode(lowPower), .modulatorClock(modClk),
    .modulatorTick(modTick), .supplyConverterBandCode(band),
    .conversionEnable(convEn)
  );

  host_model host_model_i (
    .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr)
  );

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) sinceRel <= 0;
    else sinceRel <= sinceRel + 1;
  end

  task automatic finishTest;
    $display("mismatches %0d comparisons %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [`ADDR_W-1:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    bit ok;
    host_model_i.xfer(wr, a, d, s, rd, err, ok);
    if (!ok) begin
      nErrors++;
      finishTest();
    end
  endtask

  task automatic wreg(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // Samples one full modulator period; a second call sees the new ratio
  task automatic measure(output int hi, output int lo, output int tk);
    int k;
    hi = 0;
    lo = 0;
    tk = 0;
    for (k = 0; k < 40 && modClk !== 1'b0; k++) @(posedge ref_clk);
    for (k = 0; k < 40 && modClk !== 1'b1; k++) @(posedge ref_clk);
    while (modClk === 1'b1 && hi < 40) begin
      tk += (modTick === 1'b1);
      hi++;
      @(posedge ref_clk);
    end
    while (modClk === 1'b0 && lo < 40) begin
      tk += (modTick === 1'b1);
      lo++;
      @(posedge ref_clk);
    end
  endtask

  task automatic tReset;
    for (int ch = 0; ch < `NUM_CH; ch++) begin
      check(routeSel[ch], 4'h1);
      check(chGain[ch], 3'h0);
      check(fullScale[ch], 1200000);
      check(testLevel[ch], 160000);
    end
    check(precharge, 3'h0);
    check(convEn, 1'b0);
    check({highRes, lowPower}, 2'h2);
    check(modClk, 1'b0);
    check(modTick, 1'b0);
    check(band, 4'h0);
  endtask

  task automatic tSettle;
    int hi, lo, tk, k;
    bus(1'b0, `OFS_STATUS, 32'h0, 4'h0);
    check(rd[0], 1'b0);
    check(band, 4'h8);
    check(rd[1], 1'b1);
    measure(hi, lo, tk);
    check(hi, 1);
    check(lo, 1);
    for (k = 0; k < 2000 && convEn !== 1'b1; k++) @(posedge ref_clk);
    check(sinceRel, 500);
    bus(1'b0, `OFS_STATUS, 32'h0, 4'h0);
    check(rd[0], 1'b1);
  endtask

  task automatic tSelect;
    logic [31:0] v;
    for (int c = 0; c < 4; c++) begin
      v = 0;
      for (int ch = 0; ch < `NUM_CH; ch++) v |= ((c + ch) % 4) << (2 * ch);
      wreg(`OFS_CHAN_CFG, v);
      for (int ch = 0; ch < `NUM_CH; ch++)
        check(routeSel[ch], 4'h1 << ((c + ch) % 4));
      bus(1'b0, `OFS_CHAN_CFG, 32'h0, 4'h0);
      check(rd, v);
    end
  endtask

  task automatic tGain;
    int e;
    for (int g = 0; g < 8; g++) begin
      wreg(`OFS_GAIN, g | ((7 - g) << 4) | (g << 8));
      for (int ch = 0; ch < `NUM_CH; ch++) begin
        e = (ch == 1) ? 7 - g : g;
        check(chGain[ch], e);
        check(precharge[ch], e >= 3);
        check(fullScale[ch], 1200000 >> e);
        check(testLevel[ch], 160000 >> e);
        check(testLevel[ch] * 15, fullScale[ch] * 2);
      end
    end
  endtask

  task automatic tPower;
    for (int p = 0; p < 4; p++) begin
      wreg(`OFS_CLOCK, p << 2);
      check({highRes, lowPower}, (p >= 2) ? 2'h2 : 2'h1);
    end
  endtask

  task automatic tDivider;
    int ratio[4] = '{2, 4, 8, 12};
    int hi, lo, tk;
    for (int d = 0; d < 4; d++) begin
      wreg(`OFS_CLOCK, 32'h8 | d);
      measure(hi, lo, tk);
      measure(hi, lo, tk);
      check(hi, ratio[d] / 2);
      check(lo, ratio[d] / 2);
      check(tk, 1);
      bus(1'b0, `OFS_STATUS, 32'h0, 4'h0);
      check(rd[5:4], d);
      check(rd[10:8], ratio[d] / 2);
    end
  endtask

  task automatic tBand;
    for (int b = 0; b < 16; b++) begin
      wreg(`OFS_SUPPLY, b);
      check(band, b);
    end
  endtask

  // Refused and strobe-less writes must leave the clock and channel setup alone
  task automatic tRefused;
    bus(1'b0, 8'h14, 32'h0, 4'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    bus(1'b1, `OFS_STATUS, 32'hffffffff, 4'hf);
    check(err, 1'b1);
    bus(1'b1, `OFS_CLOCK, 32'h0, 4'h0);
    bus(1'b0, `OFS_STATUS, 32'h0, 4'h0);
    check(rd[5:4], 2'h3);
    check(highRes, 1'b1);
    bus(1'b1, `OFS_CHAN_CFG, 32'h0, 4'h0);
    bus(1'b0, `OFS_CHAN_CFG, 32'h0, 4'h0);
    check(rd, 32'h13);
  endtask

  initial begin
    nErrors = 0;
    cmpCount = 0;
    resetn = 1'b0;
    repeat (7) @(posedge ref_clk);
    tReset();
    @(posedge ref_clk);
    resetn <= 1'b1;
    wreg(`OFS_SUPPLY, 32'h8);
    tSettle();
    tSelect();
    tGain();
    tPower();
    tDivider();
    tBand();
    tRefused();
    finishTest();
  end
endmodule
